// *** core/csdl_defs.vh ***
`ifndef CSDL_DEFS_VH
`define CSDL_DEFS_VH
`define CSDL_SFR_CODE_LIMIT 8'hC2
`define CSDL_SFR_TIMED 8'hC7
`define CSDL_TA_KEY1 8'hAA
`define CSDL_TA_KEY2 8'h55
`define CSDL_TA_WINDOW 2'h3
`define CSDL_CLS_UPPER 5'h1E
`define CSDL_DATA_TOP 16'h03FF
`define CSDL_VECTOR_TOP 16'h007F
`define CSDL_OPT_ADDR 16'h00FC
`define CSDL_SIG_MAKER 16'h0030
`define CSDL_SIG_PART 16'h0031
`define CSDL_SIG_EXT 16'h0060
`define CSDL_OPT_WDT_BIT 3
`define CSDL_BLANK 8'hFF
`define CSDL_STROBE_LAST 2'h2
`define CSDL_MODE_NORMAL 2'h0
`define CSDL_MODE_IAP 2'h1
`define CSDL_MODE_LOADER 2'h2
`define CSDL_MODE_PARALLEL 2'h3
`define CSDL_VSEL_CODE 2'h0
`define CSDL_VSEL_OPTION 2'h1
`define CSDL_VSEL_SIG 2'h2
`define CSDL_MV_RI 2'h0
`define CSDL_MV_PTR 2'h1
`define CSDL_MV_TABLE 2'h2
`endif

// *** core/csdl_enc_mem.v ***
`timescale 1ns/1ps
// Encryption array; registered read keeps verify timing fixed
module csdl_enc_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = 64,
  parameter AW = 6
) (
  input wire clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // csdl_enc_mem

// *** core/csdl_top.v ***
`timescale 1ns/1ps
`include "csdl_defs.vh"
module csdl_top #(
  parameter [2:0] FULL_SIZE_CODE = 3'h7,
  parameter [2:0] LOCK_INIT = 3'h7,
  parameter [7:0] MAKER_CODE = 8'h5A,
  parameter [7:0] PART_CODE = 8'h11,
  parameter [7:0] EXT_CODE = 8'h22
) (
  input wire clk,
  input wire nrst,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  input wire [1:0] prog_mode,
  input wire lock_prog_req,
  input wire [2:0] lock_prog_data,
  input wire mass_erase_req,
  input wire opt_prog_req,
  input wire [7:0] opt_prog_data,
  input wire opt_erase_req,
  input wire enc_wr_req,
  input wire [5:0] enc_addr,
  input wire [7:0] enc_wdata,
  input wire verify_req,
  input wire [1:0] verify_sel,
  input wire [15:0] verify_addr,
  input wire [7:0] verify_flash_data,
  output reg verify_valid,
  output reg [7:0] verify_data,
  output reg verify_refused,
  input wire external_fetch_force_n,
  input wire fetch_req,
  input wire [15:0] fetch_addr,
  input wire page_mode,
  input wire page_hit,
  output reg fetch_onchip,
  output reg fetch_done,
  output reg fetch_fault,
  output reg [7:0] fetch_data,
  output reg cpu_stall,
  input wire move_req,
  input wire [1:0] move_kind,
  input wire move_wr,
  input wire move_from_ext,
  input wire [7:0] work_reg_low,
  input wire [7:0] high_port_latch,
  input wire [15:0] ptr0,
  input wire [15:0] ptr1,
  input wire [7:0] pointer_choice_reg,
  input wire [7:0] move_wdata,
  output reg move_internal,
  output reg move_blocked,
  output reg move_done,
  output reg [7:0] move_rdata,
  output reg program_fetch_strobe_n,
  output reg read_strobe_n,
  output reg write_strobe_n,
  output reg [7:0] low_address_data_port_out,
  output reg low_address_data_port_oe,
  input wire [7:0] low_address_data_port_in,
  output reg [7:0] high_address_port_out,
  output reg high_address_port_oe,
  output reg [2:0] onchip_code_limit,
  output reg wdt_por_enable,
  output reg prog_permit
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_STRB = 2'h2;
  localparam ST_END = 2'h3;

  reg [2:0] lock = LOCK_INIT;
  reg opt_wdt = 1'b1;
  reg [63:0] enc_valid = 64'h0000_0000_0000_0000;
  reg ea_s1, ea_s2, ea_latched, ea_caught;
  reg [7:0] port_s1, port_s2;
  reg ta_armed;
  reg [1:0] ta_open;
  reg [1:0] state, strb_cnt;
  reg bus_fetch, bus_wr;
  reg v_pend, v_key_ok;
  reg [1:0] v_sel;
  reg [15:0] v_addr;
  reg [7:0] v_flash;
  wire [7:0] enc_key_raw;

  // Lock levels are cumulative: a deeper bit implies the shallower ones
  wire lb1_on = ~lock[0] | ~lock[1] | ~lock[2];
  wire lb2_on = ~lock[1] | ~lock[2];
  wire lb3_on = ~lock[2];
  wire prog_gated = (prog_mode == `CSDL_MODE_LOADER) ||
    (prog_mode == `CSDL_MODE_PARALLEL);
  wire ea_eff_n = lb1_on ? ea_latched : ea_s2;

  reg [15:0] limit_top;
  always @* begin
    case (onchip_code_limit)
      3'h1: limit_top = 16'h03FF;
      3'h2: limit_top = 16'h07FF;
      3'h3: limit_top = 16'h0FFF;
      3'h4: limit_top = 16'h1FFF;
      3'h5: limit_top = 16'h3FFF;
      3'h6: limit_top = 16'h7FFF;
      3'h7: limit_top = 16'hFFFF;
      default: limit_top = 16'h0000;
    endcase
  end
  wire limit_none = (onchip_code_limit == 3'h0);

  // Same-cycle compare, so on-chip fetches never wait on the decode
  wire fetch_in_chip = ea_eff_n && !limit_none &&
    (fetch_addr <= limit_top);

  wire [15:0] ptr_sel = pointer_choice_reg[0] ? ptr1 : ptr0;
  wire [15:0] move_addr = (move_kind == `CSDL_MV_RI) ?
    {high_port_latch, work_reg_low} : ptr_sel;
  wire move_is_table = (move_kind == `CSDL_MV_TABLE);
  wire table_in_chip = ea_eff_n && !limit_none && (move_addr <= limit_top);
  wire data_in_chip = (move_addr <= `CSDL_DATA_TOP);
  wire move_in_chip = move_is_table ? table_in_chip : data_in_chip;
  wire move_deny = move_from_ext && move_in_chip &&
    (move_is_table ? lb1_on : (lb2_on && !move_wr));

  // Pin synchronisers; the first stage feeds only the second.
  // No reset, so the pin level is through both stages at release.
  always @(posedge clk) begin
    ea_s1 <= external_fetch_force_n;
    ea_s2 <= ea_s1;
    port_s1 <= low_address_data_port_in;
    port_s2 <= port_s1;
  end

  // Pin level caught once after reset release, held until next reset
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ea_latched <= 1'b1;
      ea_caught <= 1'b0;
    end else if (!ea_caught) begin
      ea_latched <= ea_s2;
      ea_caught <= 1'b1;
    end
  end

  // Timed-access window and the limit register
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ta_armed <= 1'b0;
      ta_open <= 2'h0;
      onchip_code_limit <= FULL_SIZE_CODE;
    end else begin
      if (ta_open != 2'h0) begin
        ta_open <= ta_open - 2'h1;
      end
      if (sfr_wr && sfr_addr == `CSDL_SFR_TIMED) begin
        ta_armed <= (sfr_wdata == `CSDL_TA_KEY1);
        if (ta_armed && sfr_wdata == `CSDL_TA_KEY2) begin
          ta_open <= `CSDL_TA_WINDOW;
        end
      end else if (sfr_wr) begin
        ta_armed <= 1'b0;
      end
      // Unguarded writes are dropped silently, as the core expects
      if (sfr_wr && sfr_addr == `CSDL_SFR_CODE_LIMIT && ta_open != 2'h0) begin
        onchip_code_limit <= sfr_wdata[2:0];
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      if (sfr_addr == `CSDL_SFR_CODE_LIMIT) begin
        sfr_rdata <= {`CSDL_CLS_UPPER, onchip_code_limit};
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  // Security flash: locks, option bit, encryption bytes written state
  wire erase_all = mass_erase_req;
  wire prog_ok = !(prog_gated && lb1_on);
  // No nrst here: flash cells keep their state through a reset
  always @(posedge clk) begin
    if (erase_all) begin
      lock <= 3'h7;
      opt_wdt <= 1'b1;
      enc_valid <= 64'h0000_0000_0000_0000;
    end else begin
      if (lock_prog_req) begin
        lock <= lock & lock_prog_data;
      end
      if (opt_erase_req && prog_ok) begin
        opt_wdt <= 1'b1;
      end else if (opt_prog_req && prog_ok) begin
        opt_wdt <= opt_wdt & opt_prog_data[`CSDL_OPT_WDT_BIT];
      end
      if (enc_wr_req && prog_ok && enc_wdata != `CSDL_BLANK) begin
        enc_valid[enc_addr] <= 1'b1;
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdt_por_enable <= 1'b0;
      prog_permit <= 1'b0;
    end else begin
      wdt_por_enable <= ~opt_wdt;
      prog_permit <= prog_ok;
    end
  end

  csdl_enc_mem #(
    .WIDTH(8),
    .DEPTH(64),
    .AW(6)
  ) u_enc (
    .clk(clk),
    .wr_en(enc_wr_req && prog_ok && !erase_all),
    .wr_addr(enc_addr),
    .wr_data(enc_wdata),
    .rd_addr(verify_addr[5:0]),
    .rd_data(enc_key_raw)
  );

  // Verify: stage one reads the key, stage two forms the answer
  wire enc_any = |enc_valid;
  wire [7:0] opt_byte = {4'hF, opt_wdt, 3'h7};
  wire [7:0] enc_key = v_key_ok ? enc_key_raw : `CSDL_BLANK;
  wire v_gated = (v_sel == `CSDL_VSEL_CODE) && prog_gated && lb2_on;
  reg [7:0] v_answer;
  always @* begin
    v_answer = `CSDL_BLANK;
    if (v_sel == `CSDL_VSEL_OPTION && prog_mode != `CSDL_MODE_NORMAL) begin
      v_answer = opt_byte;
    end else if (v_sel == `CSDL_VSEL_SIG && prog_gated) begin
      if (v_addr == `CSDL_SIG_MAKER) begin
        v_answer = MAKER_CODE;
      end else if (v_addr == `CSDL_SIG_PART) begin
        v_answer = PART_CODE;
      end else if (v_addr == `CSDL_SIG_EXT) begin
        v_answer = EXT_CODE;
      end
    end else if (v_sel == `CSDL_VSEL_CODE) begin
      if (prog_mode == `CSDL_MODE_PARALLEL && v_addr == `CSDL_OPT_ADDR) begin
        v_answer = opt_byte;
      end else if (enc_any) begin
        v_answer = ~(v_flash ^ enc_key);
      end else begin
        v_answer = v_flash;
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      v_pend <= 1'b0;
      v_sel <= `CSDL_VSEL_CODE;
      v_addr <= 16'h0000;
      v_flash <= 8'h00;
      v_key_ok <= 1'b0;
      verify_valid <= 1'b0;
      verify_refused <= 1'b0;
      verify_data <= 8'h00;
    end else begin
      v_pend <= verify_req;
      if (verify_req) begin
        v_sel <= verify_sel;
        v_addr <= verify_addr;
        v_flash <= verify_flash_data;
        v_key_ok <= enc_valid[verify_addr[5:0]];
      end
      verify_valid <= v_pend && !v_gated;
      verify_refused <= v_pend && v_gated;
      if (v_pend) begin
        verify_data <= v_gated ? `CSDL_BLANK : v_answer;
      end
    end
  end

  // External bus: one access at a time, fetch wins over data moves.
  // Vectors below the vector top stay on-chip for any nonzero limit unless the pin forces external fetch.
  wire fetch_go = fetch_req && state == ST_IDLE;
  wire move_go = move_req && !fetch_req && state == ST_IDLE;
  wire fetch_ext_bad = !fetch_in_chip && lb3_on;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      strb_cnt <= 2'h0;
      bus_fetch <= 1'b0;
      bus_wr <= 1'b0;
      fetch_onchip <= 1'b0;
      fetch_done <= 1'b0;
      fetch_fault <= 1'b0;
      fetch_data <= 8'h00;
      cpu_stall <= 1'b0;
      move_internal <= 1'b0;
      move_blocked <= 1'b0;
      move_done <= 1'b0;
      move_rdata <= 8'h00;
      program_fetch_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      low_address_data_port_out <= 8'h00;
      low_address_data_port_oe <= 1'b0;
      high_address_port_out <= 8'h00;
      high_address_port_oe <= 1'b0;
    end else begin
      fetch_done <= 1'b0;
      fetch_fault <= 1'b0;
      move_internal <= 1'b0;
      move_blocked <= 1'b0;
      move_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (fetch_go) begin
            fetch_onchip <= fetch_in_chip;
            if (fetch_in_chip) begin
              fetch_done <= 1'b1;
            end else if (fetch_ext_bad) begin
              fetch_fault <= 1'b1;
            end else begin
              bus_fetch <= 1'b1;
              bus_wr <= 1'b0;
              low_address_data_port_out <= fetch_addr[7:0];
              low_address_data_port_oe <= 1'b1;
              high_address_port_out <= fetch_addr[15:8];
              high_address_port_oe <= 1'b1;
              if (page_mode && page_hit) begin
                program_fetch_strobe_n <= 1'b0;
                state <= ST_END;
              end else begin
                cpu_stall <= 1'b1;
                state <= ST_ADDR;
              end
            end
          end else if (move_go) begin
            if (move_deny) begin
              move_blocked <= 1'b1;
            end else if (move_in_chip) begin
              move_internal <= 1'b1;
            end else begin
              bus_fetch <= 1'b0;
              bus_wr <= move_wr && !move_is_table;
              low_address_data_port_out <= move_addr[7:0];
              low_address_data_port_oe <= 1'b1;
              high_address_port_out <= move_addr[15:8];
              high_address_port_oe <= 1'b1;
              bus_fetch <= move_is_table;
              cpu_stall <= 1'b1;
              state <= ST_ADDR;
              if (move_wr && !move_is_table) begin
                low_address_data_port_out <= move_addr[7:0];
              end
            end
          end
        end
        ST_ADDR: begin
          strb_cnt <= 2'h1;
          if (bus_wr) begin
            low_address_data_port_out <= move_wdata;
            write_strobe_n <= 1'b0;
          end else begin
            low_address_data_port_oe <= 1'b0;
            if (bus_fetch) begin
              program_fetch_strobe_n <= 1'b0;
            end else begin
              read_strobe_n <= 1'b0;
            end
          end
          state <= ST_STRB;
        end
        ST_STRB: begin
          strb_cnt <= strb_cnt + 2'h1;
          if (strb_cnt == `CSDL_STROBE_LAST) begin
            state <= ST_END;
          end
        end
        ST_END: begin
          program_fetch_strobe_n <= 1'b1;
          read_strobe_n <= 1'b1;
          write_strobe_n <= 1'b1;
          low_address_data_port_oe <= 1'b0;
          high_address_port_oe <= 1'b0;
          cpu_stall <= 1'b0;
          if (bus_fetch && fetch_onchip == 1'b0 && !move_done) begin
            fetch_data <= port_s2;
          end
          if (bus_fetch) begin
            fetch_done <= 1'b1;
          end
          if (!bus_fetch || bus_wr) begin
            move_done <= 1'b1;
          end
          if (!bus_fetch && !bus_wr) begin
            move_rdata <= port_s2;
          end
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // csdl_top

// *** verification/csdl_ext_mem.sv ***
`timescale 1ns/1ps
module csdl_ext_mem (
  input wire clk,
  input wire [7:0] lo_out,
  input wire lo_oe,
  input wire [7:0] hi_out,
  input wire fetch_n,
  input wire rd_n,
  input wire wr_n,
  output wire [7:0] lo_in,
  output reg [15:0] seen_addr,
  output reg [7:0] seen_wdata
);
  wire idle = fetch_n && rd_n && wr_n;
  wire [7:0] byte_val = seen_addr[7:0] ^ seen_addr[15:8] ^ 8'h3C;
  // Released bus shows the inverse so a stale byte cannot pass
  assign lo_in = (!fetch_n || !rd_n) ? byte_val : ~byte_val;
  always @(posedge clk) begin
    if (lo_oe && idle)
      seen_addr <= {hi_out, lo_out};
    if (!wr_n)
      seen_wdata <= lo_out;
  end
endmodule // csdl_ext_mem

// *** verification/csdl_top_sva.sv ***
`timescale 1ns/1ps
`include "csdl_defs.vh"
module csdl_top_sva (
  input wire clk,
  input wire nrst,
  input wire sfr_wr,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire external_fetch_force_n,
  input wire fetch_done,
  input wire fetch_fault,
  input wire fetch_onchip,
  input wire cpu_stall,
  input wire program_fetch_strobe_n,
  input wire read_strobe_n,
  input wire write_strobe_n,
  input wire low_address_data_port_oe,
  input wire high_address_port_oe,
  input wire move_done,
  input wire [2:0] onchip_code_limit
);
  wire [2:0] wdata_low = sfr_wdata[2:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_fetch_hold;
    (!program_fetch_strobe_n && cpu_stall)[*3] ##1 program_fetch_strobe_n;
  endsequence
  sequence s_read_hold;
    (!read_strobe_n)[*3] ##1 read_strobe_n;
  endsequence
  sequence s_write_hold;
    (!write_strobe_n)[*3] ##1 write_strobe_n;
  endsequence
  // Strobe low three cycles, then the completion pulse
  property p_fetch_steps;
    $fell(program_fetch_strobe_n) && cpu_stall |-> s_fetch_hold ##[0:1] fetch_done;
  endproperty
  a_fetch_steps: assert property (p_fetch_steps) else $error("fetch timing wrong");
  // Page hit: strobe low for one cycle only, no stall
  property p_page_fast;
    $fell(program_fetch_strobe_n) && !cpu_stall |=> program_fetch_strobe_n && fetch_done;
  endproperty
  a_page_fast: assert property (p_page_fast) else $error("page hit stalled");
  property p_read_steps;
    $fell(read_strobe_n) |-> s_read_hold ##[0:1] move_done;
  endproperty
  a_read_steps: assert property (p_read_steps) else $error("read timing wrong");
  property p_write_steps;
    $fell(write_strobe_n) |-> s_write_hold ##[0:1] move_done;
  endproperty
  a_write_steps: assert property (p_write_steps) else $error("write timing wrong");
  property p_fetch_bus;
    !program_fetch_strobe_n && cpu_stall |-> !low_address_data_port_oe && high_address_port_oe;
  endproperty
  a_fetch_bus: assert property (p_fetch_bus) else $error("fetch bus wrong");
  property p_write_bus;
    !write_strobe_n |-> low_address_data_port_oe && high_address_port_oe;
  endproperty
  a_write_bus: assert property (p_write_bus) else $error("write bus wrong");
  property p_forced;
    (!external_fetch_force_n)[*6] ##0 fetch_done |-> !fetch_onchip;
  endproperty
  a_forced: assert property (p_forced) else $error("forced fetch on chip");
  property p_fault_quiet;
    fetch_fault |-> program_fetch_strobe_n && !fetch_done ##1 program_fetch_strobe_n;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet) else $error("faulted fetch ran");
  // Limit may move only by the write that targets it
  property p_limit_write;
    !$stable(onchip_code_limit) |-> $past(sfr_wr) && $past(sfr_addr) == `CSDL_SFR_CODE_LIMIT
      && onchip_code_limit == $past(wdata_low);
  endproperty
  a_limit_write: assert property (p_limit_write) else $error("limit changed");
endmodule // csdl_top_sva
bind csdl_top csdl_top_sva csdl_top_sva_i (.*);

// *** verification/tb_csdl_top.sv ***
`timescale 1ns/1ps
`include "csdl_defs.vh"
module tb_csdl_top;
  localparam [7:0] MAKER = 8'h6B; // Arbitrary value
  localparam [7:0] PART = 8'h2C; // Arbitrary value
  localparam [7:0] EXTN = 8'h07; // Arbitrary value
  reg clk = 0, nrst = 0, sfr_wr = 0, sfr_rd = 0, lock_prog_req = 0, mass_erase_req = 0;
  reg opt_prog_req = 0, opt_erase_req = 0, enc_wr_req = 0, verify_req = 0, fetch_req = 0;
  reg page_mode = 0, page_hit = 0, move_req = 0, move_wr = 0, move_from_ext = 0;
  reg external_fetch_force_n = 1;
  reg [7:0] sfr_addr = 0, sfr_wdata = 0, opt_prog_data = 0, enc_wdata = 0, verify_flash_data = 0;
  reg [7:0] work_reg_low = 0, high_port_latch = 0, pointer_choice_reg = 0, move_wdata = 0;
  reg [1:0] prog_mode = 0, verify_sel = 0, move_kind = 0;
  reg [2:0] lock_prog_data = 0;
  reg [5:0] enc_addr = 0;
  reg [15:0] verify_addr = 0, fetch_addr = 0, ptr0 = 0, ptr1 = 0, seen_addr;
  reg [16:0] top;
  wire [7:0] sfr_rdata, verify_data, fetch_data, move_rdata, low_address_data_port_out;
  wire [7:0] low_address_data_port_in, high_address_port_out, seen_wdata;
  wire [15:0] seen_addr_w;
  wire [2:0] onchip_code_limit;
  wire verify_valid, verify_refused, fetch_onchip, fetch_done, fetch_fault, cpu_stall;
  wire move_internal, move_blocked, move_done, program_fetch_strobe_n, read_strobe_n;
  wire write_strobe_n, low_address_data_port_oe, high_address_port_oe, wdt_por_enable, prog_permit;
  integer error_cnt = 0, tests_run = 0, n, c;
  csdl_top #(.MAKER_CODE(MAKER), .PART_CODE(PART), .EXT_CODE(EXTN)) csdl_top_i (.*);
  csdl_ext_mem csdl_ext_mem_i (.clk(clk), .lo_out(low_address_data_port_out),
    .lo_oe(low_address_data_port_oe), .hi_out(high_address_port_out),
    .fetch_n(program_fetch_strobe_n), .rd_n(read_strobe_n), .wr_n(write_strobe_n),
    .lo_in(low_address_data_port_in), .seen_addr(seen_addr_w), .seen_wdata(seen_wdata));
  always #25 clk = ~clk;
  always @* seen_addr = seen_addr_w;
  task tick;
    @(posedge clk);
    #1;
  endtask
  task chk(input [15:0] s, input [15:0] e, input string nm);
    tests_run = tests_run + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  function [7:0] ext_byte(input [15:0] a);
    ext_byte = a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  task sw(input [7:0] a, input [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    tick;
  endtask
  // Strobe held across the three writes so the unlock stays armed
  task set_limit(input [2:0] v); // Only called with no fetch in flight
    sfr_wr = 1;
    sw(`CSDL_SFR_TIMED, `CSDL_TA_KEY1);
    sw(`CSDL_SFR_TIMED, `CSDL_TA_KEY2);
    sw(`CSDL_SFR_CODE_LIMIT, {5'h00, v});
    sfr_wr = 0;
    tick;
  endtask
  task wait_end;
    n = 0;
    while ((fetch_done | fetch_fault | move_done | move_internal | move_blocked) !== 1'b1
      && n < 20) begin
      tick;
      n = n + 1;
    end
  endtask
  task fetch(input [15:0] a, input on, input f);
    fetch_addr = a;
    fetch_req = 1;
    tick;
    fetch_req = 0;
    wait_end;
    chk(fetch_fault, f, "fetch_fault");
    if (!f) chk(fetch_onchip, on, "fetch_onchip");
    if (on) chk(n, 0, "onchip_wait");
    if (!on && !f) chk(n, 4, "ext_wait");
    if (!on && !f) chk(fetch_data, ext_byte(a), "fetch_data");
    if (!on && !f) chk(seen_addr, a, "fetch_addr");
  endtask
  task move(input [1:0] k, input w, input [2:0] e);
    move_kind = k;
    move_wr = w;
    move_req = 1;
    tick;
    move_req = 0;
    wait_end;
    chk({move_internal, move_blocked, move_done}, e, "move_result");
  endtask
  task verify(input [1:0] s, input [15:0] a, input [7:0] fd, input [7:0] e, input r);
    verify_sel = s;
    verify_addr = a;
    verify_flash_data = fd;
    verify_req = 1;
    tick;
    verify_req = 0;
    tick;
    chk({verify_valid, verify_refused}, {!r, r}, "verify_flags");
    if (!r) chk(verify_data, e, "verify_data");
  endtask
  task lock(input [2:0] d);
    lock_prog_data = d;
    lock_prog_req = 1;
    tick;
    lock_prog_req = 0;
    tick;
  endtask
  task erase;
    mass_erase_req = 1;
    tick;
    mass_erase_req = 0;
    tick;
  endtask
  task finish_test;
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) tick;
    nrst = 1;
    chk(onchip_code_limit, 3'h7, "limit_reset");
    fetch(16'h0000, 1, 0);
    fetch(16'hFFFF, 1, 0);
    sfr_wr = 1;
    sw(`CSDL_SFR_CODE_LIMIT, 8'h03);
    sfr_wr = 0;
    tick;
    chk(onchip_code_limit, 3'h7, "limit_locked");
    for (c = 0; c < 8; c = c + 1) begin
      set_limit(c[2:0]);
      chk(onchip_code_limit, c[2:0], "limit_set");
      sfr_addr = `CSDL_SFR_CODE_LIMIT;
      sfr_rd = 1;
      tick;
      sfr_rd = 0;
      tick;
      chk(sfr_rdata, {`CSDL_CLS_UPPER, c[2:0]}, "limit_read");
      top = (17'h0_0200 << c) - 17'h0_0001;
      if (c != 0) fetch(top[15:0], 1, 0);
      if (c != 7) fetch(c == 0 ? 16'h0000 : top[15:0] + 16'h0001, 0, 0);
    end
    external_fetch_force_n = 0;
    repeat (4) tick;
    fetch(16'h0100, 0, 0);
    external_fetch_force_n = 1;
    repeat (4) tick;
    work_reg_low = 8'h34;
    high_port_latch = 8'h12;
    move(`CSDL_MV_RI, 0, 3'b001);
    chk(seen_addr, 16'h1234, "move_addr");
    chk(move_rdata, ext_byte(16'h1234), "move_rdata");
    ptr0 = 16'h0100;
    ptr1 = 16'h4567;
    pointer_choice_reg = 8'h01;
    move_wdata = 8'h99;
    move(`CSDL_MV_PTR, 1, 3'b001);
    chk(seen_addr, 16'h4567, "ptr_addr");
    chk(seen_wdata, 8'h99, "ptr_wdata");
    pointer_choice_reg = 8'h00;
    move(`CSDL_MV_PTR, 0, 3'b100);
    prog_mode = `CSDL_MODE_PARALLEL;
    erase;
    chk(prog_permit, 1, "permit_open");
    verify(`CSDL_VSEL_CODE, 16'h0005, 8'hA5, 8'hA5, 0);
    verify(`CSDL_VSEL_OPTION, 16'h0000, 8'h00, 8'hFF, 0);
    opt_prog_data = 8'hF7;
    opt_prog_req = 1;
    tick;
    opt_prog_req = 0;
    tick;
    verify(`CSDL_VSEL_OPTION, 16'h0000, 8'h00, 8'hF7, 0);
    verify(`CSDL_VSEL_CODE, `CSDL_OPT_ADDR, 8'h00, 8'hF7, 0);
    nrst = 0;
    tick;
    nrst = 1;
    tick;
    chk(wdt_por_enable, 1, "wdt_default");
    verify(`CSDL_VSEL_SIG, `CSDL_SIG_MAKER, 8'h00, MAKER, 0);
    verify(`CSDL_VSEL_SIG, `CSDL_SIG_PART, 8'h00, PART, 0);
    verify(`CSDL_VSEL_SIG, `CSDL_SIG_EXT, 8'h00, EXTN, 0);
    enc_addr = 6'h05;
    enc_wdata = 8'h0F;
    enc_wr_req = 1;
    tick;
    enc_wr_req = 0;
    tick;
    verify(`CSDL_VSEL_CODE, 16'h0005, 8'hA5, 8'h55, 0);
    verify(`CSDL_VSEL_CODE, 16'h0006, 8'h3C, 8'h3C, 0);
    lock(3'b110);
    chk(prog_permit, 0, "permit_locked");
    external_fetch_force_n = 0;
    repeat (3) tick;
    nrst = 0;
    tick;
    nrst = 1;
    external_fetch_force_n = 1;
    repeat (3) tick;
    fetch(16'h0100, 0, 0);
    nrst = 0;
    tick;
    nrst = 1;
    tick;
    move_from_ext = 1;
    move(`CSDL_MV_TABLE, 0, 3'b010);
    lock(3'b101);
    verify(`CSDL_VSEL_CODE, 16'h0005, 8'hA5, 8'h00, 1);
    move(`CSDL_MV_PTR, 0, 3'b010);
    prog_mode = `CSDL_MODE_IAP;
    verify(`CSDL_VSEL_CODE, 16'h0005, 8'hA5, 8'h55, 0);
    prog_mode = `CSDL_MODE_PARALLEL;
    move_from_ext = 0;
    lock(3'b011);
    set_limit(3'h6);
    fetch(16'h8000, 0, 1);
    lock(3'b111);
    fetch(16'h8000, 0, 1);
    erase;
    fetch(16'h8000, 0, 0);
    page_mode = 1;
    page_hit = 1;
    fetch_req = 1;
    tick;
    fetch_req = 0;
    wait_end;
    chk({cpu_stall, fetch_done, n[1:0]}, 4'h5, "page_hit");
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt = error_cnt + 1;
    finish_test;
  end
endmodule // tb_csdl_top
